/* rtl/scpm_regs.sv */
// Contract
// - latency byte at 3Eh resets to 04h, requesting very high bus priority
// - latency byte loaded only by EEPROM loader; host sees it read-only
// - capability entry at 44h returns 01h in bits 7..0
// - capability entry bits 15..8 return 00h, ending the list
// - caps bit 15 mirrors general control bit 4, D3cold wake support
// - caps bits 14..11 return 1111b, wake from D3hot, D2, D1, D0
// - caps word reads 7E22h after reset; all bits read-only, bit 15 set only from general control
// - caps bits 10 and 9 read 1, D2 and D1 supported
// - aux current bits 8..6 read 000b, or 001b when D3cold wake set
// - caps bits 2..0 read 010b, power management revision 1.1
// - bit 5 reads 1 for device init; bits 4 and 3 read 0
`timescale 1ns/1ps
`include "scpm_defs.svh"

module scpm_regs
    import scpm_pkg::*;
#(
    parameter logic DSI_REQUIRED = 1'b1
) (
    input  wire logic        clock,
    input  wire logic        nrst,
    input  wire logic        cfg_rd,
    input  wire logic        cfg_wr,
    input  wire logic [7:2]  cfg_addr,
    input  wire logic [3:0]  cfg_be,
    input  wire logic [31:0] cfg_wdata,
    output      logic [31:0] cfg_rdata,
    output      logic        cfg_ack,
    input  wire logic        ee_load,
    input  wire logic [7:0]  ee_data,
    input  wire logic [7:0]  gen_ctrl,
    output      logic [7:0]  latency_requirement_field,
    output      logic        wake_from_unpowered_flag
);

    // ----------------------------------------
    // decode
    // ----------------------------------------
    scpm_byte_t  next_latency;
    scpm_word_t  cap_list_entry;
    scpm_word_t  caps_word;
    scpm_dword_t read_mux;
    scpm_dword_t pm_dword;
    scpm_dword_t lat_dword;
    scpm_dword_t next_rdata;
    logic        next_ack;
    logic [2:0]  aux_current;
    logic        hit_lat;
    logic        hit_pm;
    logic        aux_power_wake_config_bit;
    logic        unused_ok;

    localparam scpm_byte_t LAT_OFS = `SCPM_LAT_OFS;
    localparam scpm_byte_t CAP_OFS = `SCPM_CAP_LIST_OFS;

    assign hit_lat                   = cfg_addr == LAT_OFS[7:2];
    assign hit_pm                    = cfg_addr == CAP_OFS[7:2];
    assign aux_power_wake_config_bit = gen_ctrl[`SCPM_AUX_WAKE_BIT];
    assign unused_ok                 = ^{cfg_be, cfg_wdata};

    // latency byte only follows the loader, host writes are dropped
    assign next_latency   = ee_load ? ee_data : latency_requirement_field;

    assign cap_list_entry = {`SCPM_NEXT_PTR, `SCPM_CAP_KIND};

    assign aux_current    = wake_from_unpowered_flag ? `SCPM_AUX_55MA : `SCPM_AUX_NONE;

    assign caps_word = {wake_from_unpowered_flag,
                        `SCPM_WAKE_STATES,
                        `SCPM_STATES_SUP,
                        aux_current,
                        DSI_REQUIRED,
                        `SCPM_RSVD_CLK,
                        `SCPM_SPEC_REV};

    assign pm_dword   = {caps_word, cap_list_entry};
    assign lat_dword  = {8'h00, latency_requirement_field, 16'h0000};
    assign read_mux   = hit_pm  ? pm_dword :
                        hit_lat ? lat_dword :
                                  32'h0000_0000;
    assign next_rdata = cfg_rd ? read_mux : 32'h0000_0000;
    assign next_ack   = (cfg_rd || cfg_wr) && !unused_ok ? 1'b1 : (cfg_rd || cfg_wr);

    // ----------------------------------------
    // latency storage
    // ----------------------------------------
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            latency_requirement_field <= `SCPM_LAT_RESET;
        end else begin
            latency_requirement_field <= next_latency;
        end
    end

    // ----------------------------------------
    // wake flag copy
    // ----------------------------------------
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            wake_from_unpowered_flag <= `SCPM_WAKE_RESET;
        end else begin
            wake_from_unpowered_flag <= aux_power_wake_config_bit;
        end
    end

    // ----------------------------------------
    // configuration answer
    // ----------------------------------------
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            cfg_rdata <= 32'h0000_0000;
            cfg_ack   <= 1'b0;
        end else begin
            cfg_rdata <= next_rdata;
            cfg_ack   <= next_ack;
        end
    end

    // ----------------------------------------
    // latency checks
    // ----------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);

    property p_lat_read;
        cfg_rd && hit_lat |=> cfg_rdata[23:16] == $past(latency_requirement_field);
    endproperty
    a_lat_read: assert property (p_lat_read) else $error("latency byte read wrong");

    property p_lat_dword;
        cfg_rd && hit_lat |=> cfg_rdata[31:24] == 8'h00 && cfg_rdata[15:0] == 16'h0000;
    endproperty
    a_lat_dword: assert property (p_lat_dword) else $error("latency dword spare bytes not zero");

    property p_reset_vals;
        $rose(nrst) |-> latency_requirement_field == `SCPM_LAT_RESET && !wake_from_unpowered_flag
                        && !cfg_ack && cfg_rdata == 32'h0000_0000;
    endproperty
    a_reset_vals: assert property (p_reset_vals) else $error("values after reset wrong");

    property p_lat_hold;
        !ee_load |=> $stable(latency_requirement_field);
    endproperty
    a_lat_hold: assert property (p_lat_hold) else $error("latency byte changed without load");

    property p_lat_load;
        ee_load |=> latency_requirement_field == $past(ee_data);
    endproperty
    a_lat_load: assert property (p_lat_load) else $error("loader value not taken");

    // ----------------------------------------
    // capability entry checks
    // ----------------------------------------
    property p_cap_kind;
        cfg_rd && hit_pm |=> cfg_rdata[7:0] == 8'h01;
    endproperty
    a_cap_kind: assert property (p_cap_kind) else $error("capability kind wrong");

    property p_next_ptr;
        cfg_rd && hit_pm |=> cfg_rdata[15:8] == 8'h00;
    endproperty
    a_next_ptr: assert property (p_next_ptr) else $error("next pointer not zero");

    // ----------------------------------------
    // caps word checks
    // ----------------------------------------
    property p_wake_bit;
        cfg_rd && hit_pm |=> cfg_rdata[31] == $past(wake_from_unpowered_flag);
    endproperty
    a_wake_bit: assert property (p_wake_bit) else $error("wake bit not returned on read");

    property p_wake_follow;
        1'b1 |=> wake_from_unpowered_flag == $past(aux_power_wake_config_bit);
    endproperty
    a_wake_follow: assert property (p_wake_follow) else $error("wake flag does not follow control");

    property p_wake_states;
        cfg_rd && hit_pm |=> cfg_rdata[30:27] == 4'hF && cfg_rdata[26:25] == 2'h3;
    endproperty
    a_wake_states: assert property (p_wake_states) else $error("wake or state bits wrong");

    property p_caps_clear;
        cfg_rd && hit_pm && !wake_from_unpowered_flag
            |=> cfg_rdata[31:16] == (`SCPM_CAPS_RESET | {10'h000, DSI_REQUIRED, 5'h00});
    endproperty
    a_caps_clear: assert property (p_caps_clear) else $error("caps word wrong with wake clear");

    property p_caps_set;
        cfg_rd && hit_pm && wake_from_unpowered_flag
            |=> cfg_rdata[31:16] == (`SCPM_CAPS_RESET | 16'h8040 | {10'h000, DSI_REQUIRED, 5'h00});
    endproperty
    a_caps_set: assert property (p_caps_set) else $error("caps word wrong with wake set");

    property p_aux;
        cfg_rd && hit_pm |=> cfg_rdata[24:22] == ($past(wake_from_unpowered_flag) ? 3'h1 : 3'h0);
    endproperty
    a_aux: assert property (p_aux) else $error("aux current wrong");

    property p_low_bits;
        cfg_rd && hit_pm |=> cfg_rdata[18:16] == 3'h2 && cfg_rdata[20:19] == 2'h0
                             && cfg_rdata[21] == DSI_REQUIRED;
    endproperty
    a_low_bits: assert property (p_low_bits) else $error("low caps bits wrong");

    // ----------------------------------------
    // bus answer checks
    // ----------------------------------------
    property p_wr_ack;
        cfg_wr |=> cfg_ack;
    endproperty
    a_wr_ack: assert property (p_wr_ack) else $error("write not acknowledged");

    property p_rd_ack;
        cfg_rd |=> cfg_ack;
    endproperty
    a_rd_ack: assert property (p_rd_ack) else $error("read not acknowledged");

    property p_ack_idle;
        !cfg_rd && !cfg_wr |=> !cfg_ack && cfg_rdata == 32'h0000_0000;
    endproperty
    a_ack_idle: assert property (p_ack_idle) else $error("answer without a request");

    property p_wr_noeffect;
        cfg_wr && !ee_load |=> $stable(latency_requirement_field);
    endproperty
    a_wr_noeffect: assert property (p_wr_noeffect) else $error("write altered a read-only value");

endmodule

/* rtl/scpm_defs.svh */
`ifndef SCPM_DEFS_SVH
`define SCPM_DEFS_SVH

// ----------------------------------------
// configuration offsets
// ----------------------------------------
`define SCPM_LAT_OFS        8'h3E
`define SCPM_CAP_LIST_OFS   8'h44
`define SCPM_CAPS_OFS       8'h46

// ----------------------------------------
// reset values
// ----------------------------------------
`define SCPM_LAT_RESET      8'h04
`define SCPM_CAP_LIST_RESET 16'h0001
`define SCPM_CAPS_RESET     16'h7E02
`define SCPM_WAKE_RESET     1'b0

// ----------------------------------------
// field values
// ----------------------------------------
`define SCPM_CAP_KIND       8'h01
`define SCPM_NEXT_PTR       8'h00
`define SCPM_WAKE_STATES    4'hF
`define SCPM_STATES_SUP     2'h3
`define SCPM_AUX_NONE       3'h0
`define SCPM_AUX_55MA       3'h1
`define SCPM_RSVD_CLK       2'h0
`define SCPM_SPEC_REV       3'h2

// ----------------------------------------
// field positions
// ----------------------------------------
`define SCPM_AUX_WAKE_BIT   4

`endif

/* rtl/scpm_pkg.sv */
package scpm_pkg;

    typedef logic [7:0]  scpm_byte_t;
    typedef logic [15:0] scpm_word_t;
    typedef logic [31:0] scpm_dword_t;

endpackage

/* bench/scpm_host_model.sv */
`timescale 1ns/1ps
module scpm_host_model (
    input  wire logic        clock,
    output      logic        cfg_rd,
    output      logic        cfg_wr,
    output      logic [7:2]  cfg_addr,
    output      logic [3:0]  cfg_be,
    output      logic [31:0] cfg_wdata,
    input  wire logic [31:0] cfg_rdata,
    input  wire logic        cfg_ack
);
    // ----------------------------------------
    // host side of one config cycle
    // ----------------------------------------
    initial begin
        cfg_rd = 1'b0;
        cfg_wr = 1'b0;
        cfg_addr = 6'h00;
        cfg_be = 4'h0;
        cfg_wdata = 32'h0;
    end
    task automatic xfer(input logic wr, input logic [7:2] a, output logic [31:0] d, output logic k);
        int n;
        @(negedge clock);
        cfg_rd = ~wr;
        cfg_wr = wr;
        cfg_addr = a;
        cfg_be = 4'hF;
        cfg_wdata = 32'hFFFF_FFFF;
        // request held through two rising edges; the answer shows after the first
        @(posedge clock);
        @(posedge clock);
        for (n = 0; n < 3 && cfg_ack !== 1'b1; n++) @(posedge clock);
        d = cfg_rdata;
        k = cfg_ack;
        @(negedge clock);
        cfg_rd = 1'b0;
        cfg_wr = 1'b0;
        cfg_addr = ~a;
        cfg_be = 4'h0;
        cfg_wdata = 32'h0;
    endtask
endmodule

/* bench/scpm_regs_tb_top.sv */
`timescale 1ns/1ps
module scpm_regs_tb_top;
    import scpm_pkg::*;
    logic        clock = 1'b0;
    logic        nrst, cfg_rd, cfg_wr, cfg_ack, ee_load, wake_from_unpowered_flag;
    logic [7:2]  cfg_addr;
    logic [3:0]  cfg_be;
    logic [31:0] cfg_wdata, cfg_rdata;
    scpm_byte_t  ee_data, gen_ctrl, latency_requirement_field;
    int          fails = 0;
    int          check_count = 0;
    always #12.5 clock = ~clock;
    scpm_host_model host (.clock(clock), .cfg_rd(cfg_rd), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr), .cfg_be(cfg_be),
        .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack));
    scpm_regs DUT (.clock(clock), .nrst(nrst), .cfg_rd(cfg_rd), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr),
        .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack), .ee_load(ee_load),
        .ee_data(ee_data), .gen_ctrl(gen_ctrl), .latency_requirement_field(latency_requirement_field),
        .wake_from_unpowered_flag(wake_from_unpowered_flag));
    // ----------------------------------------
    // compare and access helpers
    // ----------------------------------------
    task automatic cmp32(input string n, input scpm_dword_t e, input scpm_dword_t s);
        check_count++;
        if (s !== e) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic cmp1(input string n, input logic e, input logic s);
        check_count++;
        if (s !== e) begin
            fails++;
            $display("[ERR] %s expected %b seen %b", n, e, s);
        end
    endtask
    task automatic acc(input logic wr, input logic [7:2] a, input scpm_dword_t e, input string n);
        scpm_dword_t d;
        logic        k;
        host.xfer(wr, a, d, k);
        cmp1("cfg_ack", 1'b1, k);
        if (!wr) cmp32(n, e, d);
    endtask
    task automatic t_defaults();
        acc(1'b0, 6'h11, 32'h7E22_0001, "pm dword");
        acc(1'b0, 6'h0F, 32'h0004_0000, "latency dword");
        cmp32("latency port", 32'h04, {24'h0, latency_requirement_field});
        acc(1'b0, 6'h12, 32'h0, "unmapped dword");
    endtask
    task automatic t_writes();
        acc(1'b1, 6'h11, 32'h0, "pm write");
        acc(1'b1, 6'h0F, 32'h0, "latency write");
        acc(1'b0, 6'h11, 32'h7E22_0001, "pm after write");
        acc(1'b0, 6'h0F, 32'h0004_0000, "latency after write");
    endtask
    task automatic t_load();
        @(negedge clock);
        ee_load = 1'b1;
        ee_data = 8'hA5;
        @(negedge clock);
        ee_load = 1'b0;
        ee_data = 8'h5A;
        cmp32("loaded port", 32'hA5, {24'h0, latency_requirement_field});
        acc(1'b1, 6'h0F, 32'h0, "latency write");
        acc(1'b0, 6'h0F, 32'h00A5_0000, "loaded dword");
        @(negedge clock);
        nrst = 1'b0;
        @(negedge clock);
        nrst = 1'b1;
        acc(1'b0, 6'h0F, 32'h0004_0000, "latency after reset");
    endtask
    task automatic t_wake();
        @(negedge clock);
        gen_ctrl = 8'h10;
        repeat (2) @(negedge clock);
        cmp1("wake flag", 1'b1, wake_from_unpowered_flag);
        acc(1'b0, 6'h11, 32'hFE62_0001, "pm wake set");
        acc(1'b1, 6'h11, 32'h0, "pm write");
        acc(1'b0, 6'h11, 32'hFE62_0001, "pm wake kept");
        gen_ctrl = 8'hEF;
        repeat (2) @(negedge clock);
        cmp1("wake flag clear", 1'b0, wake_from_unpowered_flag);
        acc(1'b0, 6'h11, 32'h7E22_0001, "pm wake clear");
    endtask
    task automatic print_verdict();
        if (fails == 0 && check_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (2000) @(posedge clock);
        fails++;
        print_verdict();
    end
    initial begin
        nrst = 1'b0;
        ee_load = 1'b0;
        ee_data = 8'h00;
        gen_ctrl = 8'h00;
        repeat (10) @(posedge clock);
        @(negedge clock);
        nrst = 1'b1;
        t_defaults();
        t_writes();
        t_load();
        t_wake();
        print_verdict();
    end
endmodule
